// ===== logic/ocm_pkg.sv
// Shared constants and types for the operator console monitor
package ocm_pkg;
  // Timing: clock period and monitor entry budgets in nanoseconds
  localparam int CLK_PERIOD_NS = 50;
  localparam int MON_MAX_NS    = 20000;
  localparam int MON_IDLE_NS   = 6000;
  // Longest times round down to whole cycles
  localparam int MON_MAX_CYC   = MON_MAX_NS / CLK_PERIOD_NS;
  localparam int MON_IDLE_CYC  = MON_IDLE_NS / CLK_PERIOD_NS;
  localparam int SLOT_W        = 10;
  // Field widths
  localparam int ARG_W   = 24;
  localparam int OCT_W   = 3;
  localparam int LET_FLD = 5;
  localparam int LET_W   = 4 * LET_FLD;
  localparam int MASK_W  = 16;
  localparam int LEVEL_W = 4;
  localparam int ALD_W   = 4;
  localparam logic [LEVEL_W-1:0] LEVEL_ZERO = 4'h0;
  // Character codes
  localparam logic [7:0] CH_0     = 8'h30;
  localparam logic [7:0] CH_7     = 8'h37;
  localparam logic [7:0] CH_A     = 8'h41;
  localparam logic [7:0] CH_Y     = 8'h59;
  localparam logic [7:0] CH_Z     = 8'h5A;
  localparam logic [7:0] CH_AT    = 8'h40;
  localparam logic [7:0] CH_SP    = 8'h20;
  localparam logic [7:0] CH_LT    = 8'h3C;
  localparam logic [7:0] CH_SLASH = 8'h2F;
  localparam logic [7:0] CH_CR    = 8'h0D;
  localparam logic [7:0] CH_STAR  = 8'h2A;
  localparam logic [7:0] CH_ESC   = 8'h1B;
  localparam logic [7:0] CH_EXCL  = 8'h21;
  localparam logic [7:0] CH_DOL   = 8'h24;
  localparam logic [7:0] CH_AMP   = 8'h26;
  localparam logic [7:0] CH_DOT   = 8'h2E;
  localparam logic [7:0] CH_QUOTE = 8'h22;
  localparam logic [7:0] CH_HASH  = 8'h23;
  localparam logic [7:0] CH_QM    = 8'h3F;
  // Packed letter words, one 5-bit field per letter (A = 1)
  localparam logic [LET_W-1:0] WORD_CLEAR = {5'h0D, 5'h01, 5'h03, 5'h0C};
  localparam logic [LET_W-1:0] WORD_STOP  = {5'h13, 5'h14, 5'h0F, 5'h10};
  // Commands handed to the CPU side
  typedef enum logic [3:0] {
    CMD_NONE, CMD_LETTERS, CMD_EXAMINE, CMD_START, CMD_STEP, CMD_LOAD,
    CMD_BREAK, CMD_MANUAL, CMD_MEMTEST, CMD_LOCATION
  } ocm_cmd_t;
  // Master clear sequence
  typedef enum logic [2:0] {MC_IDLE, MC_LAMPS, MC_CLEAR, MC_TEST, MC_LEVEL} ocm_mc_t;
  // Monitor entry slot
  typedef enum logic {MS_DORMANT, MS_SLOT} ocm_ms_t;
endpackage : ocm_pkg

// ===== logic/ocm_console.sv
// Operator console monitor: panel, master clear and character interpreter
`timescale 1ns/100ps
`default_nettype none

//
// Function
// - Master clear lights red and green lamps before the routine runs.
// - Clear button, clear command, power-up or bus line start master clear.
// - Routine: green off, mask cleared, paging and interrupts off, ring mode, physical.
// - Self-test pass lights green and sets terminal to 7 bits even parity.
// - Master clear ends with level change to level 0, then stop mode.
// - Stop button acts like the typed stop command.
// - Load button acts like a typed bootstrap load character.
// - Attention button routes console input to monitor while running.
// - Monitor prints a hash at the start of each line.
// - Locked key ignores buttons; auto restart only when locked.
// - Run lamp while running; attention lamp while monitor active.
// - Run plus attention: input to monitor only, output from both.
// - Monitor never waits on the terminal; postponed work resumes later.
// - Entry lasts at most 20 us, 6 us without terminal work.
// - Octal digits and letters accumulate; letters act on return or slash.
// - At-sign or space discards the current line.
// - Less-than separates lower and upper dump bounds.
// - Escape ends monitor link while running; no effect stopped.
// - Start, step, load, breakpoint, manual, memory test only when stopped.
// - Illegal characters echo a question mark and discard the line.
// - Typed clear command runs the same master clear routine.
// - Typed stop halts without level change; exclamation continues.
module ocm_console
  import ocm_pkg::*;
(
  input  wire logic               mclk_in,
  input  wire logic               sys_rst_in,
  input  wire logic               key_locked_in,
  input  wire logic               btn_clear_in,
  input  wire logic               btn_stop_in,
  input  wire logic               btn_load_in,
  input  wire logic               btn_attn_in,
  input  wire logic               master_clear_line_in,
  input  wire logic               power_restored_in,
  input  wire logic [ALD_W-1:0]   autoload_selector_in,
  input  wire logic               self_test_done_in,
  input  wire logic               self_test_ok_in,
  input  wire logic               mask_wr_in,
  input  wire logic [MASK_W-1:0]  mask_data_in,
  input  wire logic               paging_on_in,
  input  wire logic               int_on_in,
  input  wire logic               mon_entry_in,
  input  wire logic               rx_valid_in,
  input  wire logic [7:0]         rx_char_in,
  input  wire logic               tx_ready_in,
  output logic                    rx_take_out,
  output logic                    prog_rx_valid_out,
  output logic                    rx_int_inhibit_out,
  output logic                    tx_valid_out,
  output logic [7:0]              tx_char_out,
  output logic                    lamp_red_out,
  output logic                    lamp_green_out,
  output logic                    lamp_run_out,
  output logic                    lamp_attn_out,
  output logic                    cpu_run_out,
  output logic                    mon_busy_out,
  output logic [MASK_W-1:0]       interrupt_enable_mask_out,
  output logic                    paging_on_out,
  output logic                    int_system_on_out,
  output logic                    paging_reset_ring_mode_out,
  output logic                    phys_examine_out,
  output logic                    term_7bit_even_out,
  output logic                    self_test_start_out,
  output logic                    level_change_out,
  output logic [LEVEL_W-1:0]      level_out,
  output logic                    auto_restart_out,
  output logic                    cmd_valid_out,
  output logic [3:0]              cmd_code_out,
  output logic [ARG_W-1:0]        cmd_arg_out,
  output logic [ARG_W-1:0]        cmd_lower_out,
  output logic [LET_W-1:0]        cmd_letters_out,
  output logic [ALD_W-1:0]        cmd_autoload_out
);

  ocm_mc_t              mc_state;
  ocm_ms_t              ms_state;
  logic                 pwr_up;
  logic                 run;
  logic                 attn;
  logic                 mon_active;
  logic                 mon_active_q;
  logic                 ld_req;
  logic [SLOT_W-1:0]    slot_cnt;
  logic                 slot_first;
  logic                 pend_valid;
  logic [7:0]           pend_char;
  logic                 prompt_pend;
  logic [ARG_W-1:0]     arg;
  logic [ARG_W-1:0]     lower;
  logic [LET_W-1:0]     letters;
  logic                 mc_req;
  logic                 have_char;
  logic [7:0]           cur;
  logic                 take;
  logic                 is_digit;
  logic                 is_letter;
  logic                 is_break;
  logic                 is_stop_only;
  logic                 is_legal;
  logic                 master_clear_command_hit;
  logic                 stop_hit;
  logic                 start_hit;
  logic                 esc_hit;
  logic                 echo;
  logic [7:0]           echo_char;

  ////////////////////////////////////////////////////////////////////////////
  // Panel and link decode

  assign mon_active = ~run | attn;
  // Load button is queued as a typed dollar sign
  assign have_char  = ld_req | (rx_valid_in & mon_active);
  assign cur        = ld_req ? CH_DOL : rx_char_in;
  // One character per entry, only when the echo path is free
  assign take = slot_first & have_char & ~pend_valid & ~prompt_pend & (mc_state == MC_IDLE);
  assign rx_take_out        = take & ~ld_req;
  // Program sees no input while the monitor owns the terminal
  assign prog_rx_valid_out  = rx_valid_in & run & ~attn;
  assign rx_int_inhibit_out = run & attn;
  assign lamp_run_out       = run;
  assign lamp_attn_out      = mon_active;
  assign cpu_run_out        = run;
  assign mon_busy_out       = (ms_state == MS_SLOT);
  assign tx_valid_out       = mon_busy_out & pend_valid;
  assign tx_char_out        = pend_char;
  assign level_out          = LEVEL_ZERO;

  // Master clear sources; panel button dead while locked
  assign mc_req = (btn_clear_in & ~key_locked_in) | master_clear_line_in
                  | master_clear_command_hit | pwr_up;

  ////////////////////////////////////////////////////////////////////////////
  // Character classification

  always_comb begin
    is_digit     = (cur >= CH_0) && (cur <= CH_7);
    is_letter    = (cur >= CH_A) && (cur <= CH_Y);
    is_break     = (cur == CH_AT) || (cur == CH_SP);
    is_stop_only = (cur == CH_EXCL) || (cur == CH_Z) || (cur == CH_DOL) || (cur == CH_AMP)
                   || (cur == CH_DOT) || (cur == CH_QUOTE) || (cur == CH_HASH);
    // Stop-only characters count as illegal while running
    is_legal     = is_digit || is_letter || is_break || (cur == CH_LT) || (cur == CH_SLASH)
                   || (cur == CH_CR) || (cur == CH_STAR) || (cur == CH_ESC)
                   || (is_stop_only && ~run);
    master_clear_command_hit  = take && (cur == CH_CR) && (letters == WORD_CLEAR);
    stop_hit  = (take && (cur == CH_CR) && (letters == WORD_STOP))
                || (btn_stop_in && ~key_locked_in);
    start_hit = take && (cur == CH_EXCL) && ~run;
    esc_hit   = take && (cur == CH_ESC) && run;
    echo      = take && (cur != CH_ESC);
    echo_char = is_legal ? cur : CH_QM;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master clear sequence

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      mc_state <= MC_IDLE;
    end else begin
      case (mc_state)
        MC_IDLE:  if (mc_req) mc_state <= MC_LAMPS;
        MC_LAMPS: mc_state <= MC_CLEAR;
        MC_CLEAR: mc_state <= MC_TEST;
        MC_TEST:  if (self_test_done_in) mc_state <= MC_LEVEL;
        MC_LEVEL: mc_state <= MC_IDLE;
        default:  mc_state <= MC_IDLE;
      endcase
    end
  end

  // Power-up request set while reset is held, dropped once honoured
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      pwr_up <= 1'b1;
    end else if (mc_state == MC_LAMPS) begin
      pwr_up <= 1'b0;
    end
  end

  // Lamps, machine mode bits and terminal setup
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      lamp_red_out               <= 1'b0;
      lamp_green_out             <= 1'b0;
      interrupt_enable_mask_out  <= '0;
      paging_on_out              <= 1'b0;
      int_system_on_out          <= 1'b0;
      paging_reset_ring_mode_out <= 1'b1;
      phys_examine_out           <= 1'b1;
      term_7bit_even_out         <= 1'b0;
      self_test_start_out        <= 1'b0;
      level_change_out           <= 1'b0;
    end else begin
      self_test_start_out <= (mc_state == MC_CLEAR);
      level_change_out    <= 1'b0;
      if (mask_wr_in) interrupt_enable_mask_out <= mask_data_in;
      if (paging_on_in) paging_on_out <= 1'b1;
      if (int_on_in) int_system_on_out <= 1'b1;
      case (mc_state)
        MC_LAMPS: begin
          lamp_red_out   <= 1'b1;
          lamp_green_out <= 1'b1;
        end
        MC_CLEAR: begin
          lamp_green_out             <= 1'b0;
          interrupt_enable_mask_out  <= '0;
          paging_on_out              <= 1'b0;
          int_system_on_out          <= 1'b0;
          paging_reset_ring_mode_out <= 1'b1;
          phys_examine_out           <= 1'b1;
        end
        MC_TEST: if (self_test_done_in && self_test_ok_in) begin
          lamp_green_out     <= 1'b1;
          lamp_red_out       <= 1'b0;
          term_7bit_even_out <= 1'b1;
        end
        MC_LEVEL: level_change_out <= 1'b1;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run state and attention link

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      run  <= 1'b0;
      attn <= 1'b0;
    end else if (mc_state != MC_IDLE || stop_hit) begin
      run  <= 1'b0;
      attn <= 1'b0;
    end else if (start_hit) begin
      run  <= 1'b1;
      attn <= 1'b0;
    end else if (btn_attn_in && ~key_locked_in && run) begin
      attn <= 1'b1;
    end else if (esc_hit) begin
      attn <= 1'b0;
    end
  end

  // Auto restart after power returns is allowed only under lock
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      auto_restart_out <= 1'b0;
    end else begin
      auto_restart_out <= power_restored_in && key_locked_in && (mc_state == MC_IDLE);
    end
  end

  // Load button waits until the parser can take it
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      ld_req <= 1'b0;
    end else if (btn_load_in && ~key_locked_in) begin
      ld_req <= 1'b1;
    end else if (take) begin
      ld_req <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Entry slots: short when idle, bounded when there is terminal work

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      ms_state   <= MS_DORMANT;
      slot_cnt   <= '0;
      slot_first <= 1'b0;
    end else begin
      slot_first <= 1'b0;
      case (ms_state)
        MS_DORMANT: if (mon_active && (mon_entry_in || ~run)) begin
          ms_state   <= MS_SLOT;
          slot_first <= 1'b1;
          if (pend_valid || prompt_pend || have_char) begin
            slot_cnt <= SLOT_W'(MON_MAX_CYC - 1);
          end else begin
            slot_cnt <= SLOT_W'(MON_IDLE_CYC - 1);
          end
        end
        MS_SLOT: begin
          // Slot ends on time even if the terminal never became ready
          if (slot_cnt == '0) ms_state <= MS_DORMANT;
          else slot_cnt <= slot_cnt - 1'b1;
        end
        default: ms_state <= MS_DORMANT;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Echo and prompt path; a single held character keeps output in order

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      pend_valid   <= 1'b0;
      pend_char    <= '0;
      prompt_pend  <= 1'b0;
      mon_active_q <= 1'b0;
    end else begin
      mon_active_q <= mon_active;
      if (tx_valid_out && tx_ready_in) begin
        pend_valid <= 1'b0;
      end else if (echo) begin
        pend_valid <= 1'b1;
        pend_char  <= echo_char;
      end else if (prompt_pend && ~pend_valid) begin
        pend_valid  <= 1'b1;
        pend_char   <= CH_HASH;
        prompt_pend <= 1'b0;
      end
      // New line on entry or after carriage return; set beats clear
      if ((mon_active && ~mon_active_q) || (take && cur == CH_CR)) begin
        prompt_pend <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parser and command hand-off

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      arg              <= '0;
      lower            <= '0;
      letters          <= '0;
      cmd_valid_out    <= 1'b0;
      cmd_code_out     <= 4'(CMD_NONE);
      cmd_arg_out      <= '0;
      cmd_lower_out    <= '0;
      cmd_letters_out  <= '0;
      cmd_autoload_out <= '0;
    end else begin
      cmd_valid_out <= 1'b0;
      if (mc_state == MC_CLEAR) begin
        arg     <= '0;
        lower   <= '0;
        letters <= '0;
      end else if (take) begin
        cmd_arg_out      <= arg;
        cmd_lower_out    <= lower;
        cmd_letters_out  <= letters;
        cmd_autoload_out <= autoload_selector_in;
        // Any command or break empties the buffers
        arg     <= '0;
        lower   <= '0;
        letters <= '0;
        if (is_digit) begin
          arg     <= {arg[ARG_W-OCT_W-1:0], cur[OCT_W-1:0]};
          lower   <= lower;
          letters <= letters;
        end else if (is_letter) begin
          letters <= {letters[LET_W-LET_FLD-1:0], cur[LET_FLD-1:0]};
          arg     <= arg;
          lower   <= lower;
        end else if (cur == CH_LT) begin
          lower   <= arg;
          letters <= letters;
        end else if (cur == CH_ESC) begin
          arg     <= arg;
          lower   <= lower;
          letters <= letters;
        end else if (is_legal && !is_break) begin
          cmd_valid_out <= ~master_clear_command_hit && ~stop_hit;
          if (cur == CH_CR) cmd_code_out <= 4'(CMD_LETTERS);
          else if (cur == CH_SLASH) cmd_code_out <= 4'(CMD_EXAMINE);
          else if (cur == CH_STAR) cmd_code_out <= 4'(CMD_LOCATION);
          else if (cur == CH_EXCL) cmd_code_out <= 4'(CMD_START);
          else if (cur == CH_Z) cmd_code_out <= 4'(CMD_STEP);
          else if (cur == CH_DOT) cmd_code_out <= 4'(CMD_BREAK);
          else if (cur == CH_QUOTE) cmd_code_out <= 4'(CMD_MANUAL);
          else if (cur == CH_HASH) cmd_code_out <= 4'(CMD_MEMTEST);
          else cmd_code_out <= 4'(CMD_LOAD);
        end
        // Break and illegal characters fall through with buffers emptied
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [SLOT_W-1:0] slot_len;

  // Helper: cycles spent in the current slot
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || ms_state == MS_DORMANT) slot_len <= '0;
    else slot_len <= slot_len + 1'b1;
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  property p_lamps_first;
    (mc_state == MC_IDLE) && mc_req |=> ##1 lamp_red_out && lamp_green_out;
  endproperty
  a_lamps_first: assert property (p_lamps_first) else $error("lamps not lit");

  property p_clear_state;
    (mc_state == MC_CLEAR) |=> !lamp_green_out && interrupt_enable_mask_out == '0
      && !paging_on_out && paging_reset_ring_mode_out && phys_examine_out;
  endproperty
  a_clear_state: assert property (p_clear_state) else $error("clear state wrong");

  property p_level_stop;
    level_change_out |-> level_out == LEVEL_ZERO && !cpu_run_out && lamp_attn_out;
  endproperty
  a_level_stop: assert property (p_level_stop) else $error("not stopped at level 0");

  property p_stop_btn;
    btn_stop_in && !key_locked_in |=> !cpu_run_out && lamp_attn_out;
  endproperty
  a_stop_btn: assert property (p_stop_btn) else $error("stop button ignored");

  property p_lock_attn;
    key_locked_in && btn_attn_in && cpu_run_out && !rx_int_inhibit_out
      |=> !rx_int_inhibit_out;
  endproperty
  a_lock_attn: assert property (p_lock_attn) else $error("locked button acted");

  property p_input_owner;
    lamp_run_out && lamp_attn_out |-> !prog_rx_valid_out;
  endproperty
  a_input_owner: assert property (p_input_owner) else $error("program got input");

  property p_slot_bound;
    mon_busy_out |-> slot_len < SLOT_W'(MON_MAX_CYC);
  endproperty
  a_slot_bound: assert property (p_slot_bound) else $error("slot too long");

  property p_illegal;
    take && !is_legal |=> pend_char == CH_QM && arg == '0 && letters == '0;
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal not rejected");

  property p_esc_stop;
    take && cur == CH_ESC && !cpu_run_out |=> !cpu_run_out && lamp_attn_out;
  endproperty
  a_esc_stop: assert property (p_esc_stop) else $error("escape acted in stop");

  c_mc_done: cover property (mc_state == MC_LEVEL ##1 mc_state == MC_IDLE);
  c_start:   cover property (start_hit ##1 cpu_run_out);
  c_attn:    cover property (cpu_run_out && rx_int_inhibit_out);
  c_echo:    cover property (tx_valid_out && tx_ready_in);

endmodule : ocm_console

`default_nettype wire

// ===== verification/ocm_term_model.sv
// Operator terminal model: types characters and records echoes
`timescale 1ns/100ps
`default_nettype none
module ocm_term_model (
  input  wire logic       mclk_in,
  input  wire logic       rx_take_in,
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_char_in,
  output logic            rx_valid_out,
  output logic [7:0]      rx_char_out,
  output logic            tx_ready_out,
  output logic [7:0]      last_tx_out
);
  initial begin
    rx_valid_out = 1'b0;
    rx_char_out = 8'h00;
    tx_ready_out = 1'b1;
    last_tx_out = 8'h00;
  end
  // Hold the char until taken; the released line shows garbage, not the old char
  task automatic put(input logic [7:0] c);
    rx_valid_out = 1'b1;
    rx_char_out = c;
    // Look for take off the edge, then let the consuming edge pass
    for (int k = 0; k < 3000 && rx_take_in !== 1'b1; k++) begin
      @(posedge mclk_in);
      #5;
    end
    @(posedge mclk_in);
    #5;
    rx_valid_out = 1'b0;
    rx_char_out = ~c;
  endtask : put
  // Echo capture on each accepted transfer
  always @(posedge mclk_in) begin
    if (tx_valid_in && tx_ready_out) last_tx_out <= tx_char_in;
  end
endmodule : ocm_term_model
`default_nettype wire

// ===== verification/operator_console_monitor_test.sv
// Self-checking bench for the console block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
`define WAITS(s) for (int k = 0; k < 3000 && (s) !== 1'b1; k++) tick();
module operator_console_monitor_test;
  import ocm_pkg::*;
  logic clk, rst, lock, clr, ld, mwr, pon, ion, pwr, sdone, sok, rxv, txr, txv, take;
  logic stp, atn, master_clear_line;
  logic [7:0] rxc, txc, last;
  logic [3:0] autoload_selector;
  int errors = 0;
  int n_compared = 0;
  ocm_console ocm_console_inst (.mclk_in(clk), .sys_rst_in(rst), .key_locked_in(lock),
    .btn_clear_in(clr), .btn_stop_in(stp), .btn_load_in(ld), .btn_attn_in(atn),
    .master_clear_line_in(master_clear_line), .power_restored_in(pwr), .autoload_selector_in(autoload_selector),
    .self_test_done_in(sdone), .self_test_ok_in(sok), .mask_wr_in(mwr),
    .mask_data_in(16'hFFFF), .paging_on_in(pon), .int_on_in(ion), .mon_entry_in(1'b0),
    .rx_valid_in(rxv), .rx_char_in(rxc), .tx_ready_in(txr), .rx_take_out(take),
    .prog_rx_valid_out(), .rx_int_inhibit_out(), .tx_valid_out(txv), .tx_char_out(txc),
    .lamp_red_out(), .lamp_green_out(), .lamp_run_out(), .lamp_attn_out(),
    .cpu_run_out(), .mon_busy_out(), .interrupt_enable_mask_out(), .paging_on_out(),
    .int_system_on_out(), .paging_reset_ring_mode_out(), .phys_examine_out(),
    .term_7bit_even_out(), .self_test_start_out(), .level_change_out(), .level_out(),
    .auto_restart_out(), .cmd_valid_out(), .cmd_code_out(), .cmd_arg_out(),
    .cmd_lower_out(), .cmd_letters_out(), .cmd_autoload_out());
  ocm_term_model ocm_term_model_inst (.mclk_in(clk), .rx_take_in(take), .tx_valid_in(txv),
    .tx_char_in(txc), .rx_valid_out(rxv), .rx_char_out(rxc), .tx_ready_out(txr),
    .last_tx_out(last));
  // Clock at 50 ns
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic tick();
    @(posedge clk);
    #5;
  endtask : tick
  // Follow one master clear through self-test to stop mode
  task automatic mc_run();
    `WAITS(ocm_console_inst.self_test_start_out)
    `CHK(ocm_console_inst.lamp_red_out, 1'b1)
    `CHK(ocm_console_inst.lamp_green_out, 1'b0)
    `CHK(ocm_console_inst.interrupt_enable_mask_out, 16'h0000)
    `CHK({ocm_console_inst.paging_on_out, ocm_console_inst.int_system_on_out}, 2'b00)
    `CHK({ocm_console_inst.paging_reset_ring_mode_out, ocm_console_inst.phys_examine_out}, 2'b11)
    sdone = 1'b1;
    sok = 1'b1;
    tick();
    sdone = 1'b0;
    `WAITS(ocm_console_inst.level_change_out)
    `CHK(ocm_console_inst.level_out, LEVEL_ZERO)
    `CHK({ocm_console_inst.lamp_green_out, ocm_console_inst.term_7bit_even_out}, 2'b11)
    `CHK({ocm_console_inst.cpu_run_out, ocm_console_inst.lamp_attn_out}, 2'b01)
  endtask : mc_run
  // Locked key: clear ignored, restart allowed
  task automatic locked_key();
    logic seen = 1'b0;
    logic rst_seen = 1'b0;
    lock = 1'b1;
    clr = 1'b1;
    tick();
    clr = 1'b0;
    pwr = 1'b1;
    for (int k = 0; k < 8; k++) begin
      tick();
      pwr = 1'b0;
      seen |= ocm_console_inst.self_test_start_out;
      rst_seen |= ocm_console_inst.auto_restart_out;
    end
    `CHK({seen, rst_seen}, 2'b01)
    lock = 1'b0;
  endtask : locked_key
  // Dirty the state, then clear from the panel
  task automatic panel_clear();
    {mwr, pon, ion} = 3'b111;
    tick();
    {mwr, pon, ion} = 3'b000;
    clr = 1'b1;
    tick();
    clr = 1'b0;
    mc_run();
  endtask : panel_clear
  // Examine command, illegal char, then the load button
  task automatic typing();
    ocm_term_model_inst.put(8'h31);
    ocm_term_model_inst.put(8'h32);
    ocm_term_model_inst.put(CH_SLASH);
    `WAITS(ocm_console_inst.cmd_valid_out)
    `CHK({ocm_console_inst.cmd_code_out, ocm_console_inst.cmd_arg_out}, {4'h2, 24'h00000A})
    ocm_term_model_inst.put(8'h25);
    `WAITS(last === CH_QM)
    `CHK(last, CH_QM)
    autoload_selector = 4'h3;
    ld = 1'b1;
    tick();
    ld = 1'b0;
    `WAITS(ocm_console_inst.cmd_valid_out)
    `CHK({ocm_console_inst.cmd_code_out, ocm_console_inst.cmd_autoload_out}, 8'h53)
  endtask : typing
  // Start, attention link, stop button, then bus master clear
  task automatic run_attn();
    ocm_term_model_inst.put(CH_EXCL);
    `CHK({ocm_console_inst.lamp_run_out, ocm_console_inst.lamp_attn_out}, 2'b10)
    atn = 1'b1;
    tick();
    atn = 1'b0;
    `CHK({ocm_console_inst.lamp_run_out, ocm_console_inst.lamp_attn_out, ocm_console_inst.rx_int_inhibit_out}, 3'b111)
    stp = 1'b1;
    tick();
    stp = 1'b0;
    `CHK({ocm_console_inst.cpu_run_out, ocm_console_inst.lamp_attn_out}, 2'b01)
    master_clear_line = 1'b1;
    tick();
    master_clear_line = 1'b0;
    mc_run();
  endtask : run_attn
  task automatic wrap_up();
    if (errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  // Main sequence
  initial begin
    {rst, lock, clr, ld, mwr, pon, ion, pwr, sdone, sok, autoload_selector} = {10'h200, 4'h0};
    {stp, atn, master_clear_line} = 3'b000;
    repeat (16) tick();
    rst = 1'b0;
    mc_run();
    locked_key();
    panel_clear();
    typing();
    run_attn();
    wrap_up();
  end
  // Watchdog
  initial begin
    #(40000 * 50);
    errors++;
    wrap_up();
  end
endmodule : operator_console_monitor_test
`default_nettype wire
